/* rtl/rcdr_pkg.sv */
/*
  Constants, register map and carrier types for the reset cause recorder.
  Assumes a single 20 MHz bus clock and an active-low asynchronous power-on reset.
*/
// Summary of operation
// [R1] Read-only flags name most recent reset source.
// [R2] Debug-forced reset leaves all cause flags cleared.
// [R3] Cause register write restarts watchdog, keeps flags.
// [R4] Power-on sets bits 7 and 1 only.
// [R5] Enabled low-voltage trip sets bit 1, keeps bit 7.
// [R6] Other resets flag active sources, clear rest.
// [R7] Low reset pin sets bit 6.
// [R8] Watchdog timeout sets bit 5; blocked when disabled.
// [R9] Bad opcode, disallowed stop/background set bit 4.
// [R10] Unimplemented address access sets bit 3.
// [R11] Debug-force register writable only by debug link.
// [R12] Debug-force register always reads zero.
// [R13] Debug write of one forces device reset.
// [R14] Host holds mode pin: high user, low background.
// [R15] Bits 2 and 0 read zero, ignore writes.
package rcdr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [0:0] REG_CAUSE_IDX = 1'h0;
  localparam logic [0:0] REG_FORCE_IDX = 1'h1;
  localparam int DEBUG_FORCE_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h82;
  localparam logic [2:0] SYNC_RESET_VALUE = 3'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_HOLD_NS = 500;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HOLD_LAST = 4'(RESET_HOLD_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog_reset_flag;
    logic bad_opcode_flag;
    logic bad_address_flag;
    logic unused2;
    logic low_voltage_flag;
    logic unused0;
  } rcdr_cause_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rcdr_req_t;

  typedef enum logic {RCDR_RUN, RCDR_HOLD} rcdr_state_t;

endpackage : rcdr_pkg

/* rtl/rcdr_reset_cause.sv */
/*
  Reset cause recorder with debug-forced reset.
  Assumes the CPU and the background debug logic present one-cycle register
  requests on clk, and that resetn is the power-on reset of this block only.
*/
`timescale 1ns/1ps
module rcdr_reset_cause (
  input wire logic clk,
  input wire logic resetn,
  input wire rcdr_pkg::rcdr_req_t cpu_req,
  input wire rcdr_pkg::rcdr_req_t bdm_req,
  output logic [7:0] rdata,
  input wire logic reset_pin_n,
  input wire logic low_voltage_trip,
  input wire logic background_mode_pin,
  input wire logic low_voltage_reset_enable,
  input wire logic watchdog_enable_setting,
  input wire logic stop_allowed_setting,
  input wire logic background_allowed_setting,
  input wire logic watchdog_timeout,
  input wire logic bad_opcode,
  input wire logic stop_attempt,
  input wire logic background_attempt,
  input wire logic bad_address,
  output logic watchdog_restart,
  output logic sys_reset,
  output logic background_boot
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic lv_s;
  logic pin_n_s;
  logic mode_s;

  // Pins are asynchronous; only the second stage is looked at.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= rcdr_pkg::SYNC_RESET_VALUE;
      sync2_q <= rcdr_pkg::SYNC_RESET_VALUE;
    end else begin
      sync1_q <= {low_voltage_trip, reset_pin_n, background_mode_pin};
      sync2_q <= sync1_q;
    end
  end

  assign lv_s = sync2_q[2];
  assign pin_n_s = sync2_q[1];
  assign mode_s = sync2_q[0];

  // ----------------------------------------------------------------------
  // Cause detection
  // ----------------------------------------------------------------------
  logic pin_c;
  logic wd_c;
  logic op_c;
  logic ad_c;
  logic lv_c;
  logic dbg_c;
  logic any_c;

  // Program writes to the force register never reach here.
  assign dbg_c = bdm_req.wr && bdm_req.sel == rcdr_pkg::REG_FORCE_IDX
                 && bdm_req.wdata[rcdr_pkg::DEBUG_FORCE_BIT]; // R11 R13
  assign pin_c = !pin_n_s; // R7
  assign wd_c = watchdog_timeout && watchdog_enable_setting; // R8
  assign op_c = bad_opcode || (stop_attempt && !stop_allowed_setting)
                || (background_attempt && !background_allowed_setting); // R9
  assign ad_c = bad_address; // R10
  assign lv_c = lv_s && low_voltage_reset_enable; // R5
  assign any_c = pin_c || wd_c || op_c || ad_c || lv_c || dbg_c;

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  rcdr_pkg::rcdr_state_t state_q;
  logic [3:0] hold_q;
  logic leave;

  // A held pin or an enabled supply trip keeps the device in reset past the minimum.
  assign leave = state_q == rcdr_pkg::RCDR_HOLD && hold_q == rcdr_pkg::HOLD_LAST && !pin_c && !lv_c;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= rcdr_pkg::RCDR_RUN;
    end else begin
      unique case (state_q)
        rcdr_pkg::RCDR_RUN: begin
          if (any_c) begin
            state_q <= rcdr_pkg::RCDR_HOLD; // R13
          end
        end
        rcdr_pkg::RCDR_HOLD: begin
          if (leave) begin
            state_q <= rcdr_pkg::RCDR_RUN;
          end
        end
      endcase
    end
  end

  // Minimum hold counter, saturating at its last value.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 4'h0;
    end else if (state_q == rcdr_pkg::RCDR_RUN) begin
      hold_q <= 4'h0;
    end else if (hold_q != rcdr_pkg::HOLD_LAST) begin
      hold_q <= hold_q + 4'h1;
    end
  end

  assign sys_reset = state_q == rcdr_pkg::RCDR_HOLD;

  // The mode pin is read as the device leaves a reset; low selects background.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      background_boot <= 1'b0;
    end else if (leave) begin
      background_boot <= !mode_s; // R14
    end
  end

  // ----------------------------------------------------------------------
  // Cause flags
  // ----------------------------------------------------------------------
  rcdr_pkg::rcdr_cause_t flags_q;

  // Flags are captured once, at reset entry; the reserved bits are never set.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= rcdr_pkg::CAUSE_POR_VALUE; // R4
    end else if (state_q == rcdr_pkg::RCDR_RUN && any_c) begin
      if (lv_c) begin
        flags_q <= '{power_on: flags_q.power_on, low_voltage_flag: 1'b1, default: 1'b0}; // R5
      end else begin
        // Debug force contributes no bit of its own.
        flags_q <= '{pin: pin_c, watchdog_reset_flag: wd_c, bad_opcode_flag: op_c,
                     bad_address_flag: ad_c, default: 1'b0}; // R1 R2 R6 R15
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  // Read data is registered; the force register has no readable state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (cpu_req.rd) begin
      rdata <= (cpu_req.sel == rcdr_pkg::REG_CAUSE_IDX) ? flags_q : 8'h00; // R1 R12
    end
  end

  // Any program write to the cause register only kicks the watchdog.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_restart <= 1'b0;
    end else begin
      watchdog_restart <= cpu_req.wr && cpu_req.sel == rcdr_pkg::REG_CAUSE_IDX; // R3
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic first_q;
  logic entry;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  assign entry = state_q == rcdr_pkg::RCDR_RUN && any_c;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  por_flags_a: assert property (first_q |-> flags_q == rcdr_pkg::CAUSE_POR_VALUE) // R4
    else $error("Power-on flags wrong.");
  lv_entry_a: assert property (entry && lv_c |=> flags_q == {$past(flags_q.power_on), 7'h02}) // R5
    else $error("Low-voltage entry flags wrong.");
  other_entry_a: assert property (entry && !lv_c |=> flags_q == {1'b0, $past(pin_c), $past(wd_c), // R6
                                  $past(op_c), $past(ad_c), 3'h0})
    else $error("Reset entry flags wrong.");
  debug_clear_a: assert property (entry && dbg_c && !(pin_c || wd_c || op_c || ad_c || lv_c) // R2
                                  |=> flags_q == 8'h00)
    else $error("Debug reset left a flag set.");
  kick_keep_a: assert property (cpu_req.wr && cpu_req.sel == rcdr_pkg::REG_CAUSE_IDX && !entry // R3
                                |=> watchdog_restart && $stable(flags_q))
    else $error("Watchdog kick wrong.");
  force_read_a: assert property (cpu_req.rd && cpu_req.sel == rcdr_pkg::REG_FORCE_IDX // R12
                                 |=> rdata == 8'h00)
    else $error("Force register read nonzero.");
  cpu_force_a: assert property (state_q == rcdr_pkg::RCDR_RUN && cpu_req.wr && !any_c // R11
                                |=> !sys_reset)
    else $error("Program write forced reset.");
  // A timeout alone, with the watchdog disabled, must not take the device into reset.
  wd_block_a: assert property (state_q == rcdr_pkg::RCDR_RUN && watchdog_timeout && !watchdog_enable_setting // R8
                               && !(pin_c || op_c || ad_c || lv_c || dbg_c) |=> !sys_reset)
    else $error("Watchdog reset while disabled.");
  force_reset_a: assert property (state_q == rcdr_pkg::RCDR_RUN && dbg_c // R13
                                  |=> sys_reset [*2])
    else $error("Debug force did not reset.");
  reserved_zero_a: assert property (rdata[2] == 1'b0 && rdata[0] == 1'b0) // R15
    else $error("Reserved bits nonzero.");
  cause_read_a: assert property (cpu_req.rd && cpu_req.sel == rcdr_pkg::REG_CAUSE_IDX // R1
                                 |=> rdata == $past(flags_q))
    else $error("Cause read mismatch.");
  opcode_flag_a: assert property (entry && !lv_c && stop_attempt && !stop_allowed_setting // R9
                                  |=> flags_q.bad_opcode_flag)
    else $error("Stop attempt not flagged.");

endmodule : rcdr_reset_cause

/* verif/rcdr_debug_host.sv */
/*
  Debug host model on the single-wire background link.
  Assumes the bench forks its task and leaves it 14 cycles to finish.
*/
`timescale 1ns/1ps
module rcdr_debug_host (
  input wire logic clk,
  output rcdr_pkg::rcdr_req_t bdm_req,
  output logic background_mode_pin
);
  // ------------------------------
  // Forced reset over the link
  // ------------------------------
  // The pin has a pull-up, so an idle host leaves it high.
  initial begin
    bdm_req = '0;
    background_mode_pin = 1'b1;
  end

  // One write cycle. The mode level is then held until the device has left reset.
  task automatic force_reset(input logic [7:0] data, input logic mode);
    @(negedge clk);
    bdm_req <= '{sel: 1'h1, wr: 1'h1, rd: 1'h0, wdata: data};
    @(negedge clk);
    bdm_req <= '0;
    background_mode_pin <= mode;
    repeat (12) @(negedge clk);
    background_mode_pin <= 1'b1;
  endtask : force_reset
endmodule : rcdr_debug_host

/* verif/rcdr_reset_cause_tb.sv */
/*
  Self-checking bench for the reset cause recorder.
  Assumes the debug host model drives the link side and the mode pin.
*/
`timescale 1ns/1ps
module rcdr_reset_cause_tb;
  logic clk;
  logic resetn;
  rcdr_pkg::rcdr_req_t cpu_req;
  rcdr_pkg::rcdr_req_t bdm_req;
  logic [7:0] rdata;
  logic pin_n, trip, mode_pin, lv_en, wd_en, stop_ok, bg_ok;
  logic wd_to, bad_op, stop_try, bg_try, bad_ad, restart, sys_reset, boot;
  int fails = 0;
  int n_tests = 0;
  // Settings {lv, wd, stop, bg}, sources {pin, trip, wd, op, stop, bg, addr}, reset expected, flags.
  localparam logic [19:0] TBL [12] = '{
    {4'h0, 7'h10, 1'h0, 8'h00}, {4'h4, 7'h10, 1'h1, 8'h20}, {4'h4, 7'h40, 1'h1, 8'h40},
    {4'h4, 7'h08, 1'h1, 8'h10}, {4'h6, 7'h04, 1'h0, 8'h00}, {4'h4, 7'h04, 1'h1, 8'h10},
    {4'h5, 7'h02, 1'h0, 8'h00}, {4'h4, 7'h02, 1'h1, 8'h10}, {4'h4, 7'h01, 1'h1, 8'h08},
    {4'h4, 7'h18, 1'h1, 8'h30}, {4'h4, 7'h20, 1'h0, 8'h00}, {4'hc, 7'h20, 1'h1, 8'h02}
  };

  rcdr_reset_cause u_rcdr_reset_cause (
    .clk(clk), .resetn(resetn), .cpu_req(cpu_req), .bdm_req(bdm_req), .rdata(rdata),
    .reset_pin_n(pin_n), .low_voltage_trip(trip), .background_mode_pin(mode_pin),
    .low_voltage_reset_enable(lv_en), .watchdog_enable_setting(wd_en),
    .stop_allowed_setting(stop_ok), .background_allowed_setting(bg_ok),
    .watchdog_timeout(wd_to), .bad_opcode(bad_op), .stop_attempt(stop_try),
    .background_attempt(bg_try), .bad_address(bad_ad), .watchdog_restart(restart),
    .sys_reset(sys_reset), .background_boot(boot)
  );
  rcdr_debug_host u_rcdr_debug_host (.clk(clk), .bdm_req(bdm_req), .background_mode_pin(mode_pin));

  // ------------------------------
  // Bus tasks and checks
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  // One-cycle request; read data and the restart pulse are looked at one cycle later.
  task automatic access(input logic wr, input logic sel, input logic [7:0] d);
    @(negedge clk);
    cpu_req <= '{sel: sel, wr: wr, rd: !wr, wdata: d};
    @(negedge clk);
    cpu_req <= '0;
  endtask : access

  // Bounded waits, so a reset that never comes or never ends cannot hang the run.
  task automatic ride_reset(input logic [7:0] exp);
    int n;
    n = 0;
    while (sys_reset !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("reset entry", 8'h01, {7'h00, sys_reset});
    while (sys_reset !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    access(1'b0, 1'b0, 8'h00);
    chk("cause flags", exp, rdata);
  endtask : ride_reset

  task automatic cause(input logic [6:0] v, input logic go, input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    @(negedge clk);
    {pin_n, trip, wd_to, bad_op, stop_try, bg_try, bad_ad} <= v ^ 7'h40;
    repeat (3) @(negedge clk);
    {pin_n, trip, wd_to, bad_op, stop_try, bg_try, bad_ad} <= 7'h40;
    if (go) begin
      ride_reset(exp);
    end else begin
      repeat (20) begin
        @(negedge clk);
        seen = seen | sys_reset;
      end
      chk("no reset", 8'h00, {7'h00, seen});
    end
  endtask : cause

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    logic [6:0] v;
    logic go;
    logic [7:0] e;
    cpu_req = '0;
    {pin_n, trip, wd_to, bad_op, stop_try, bg_try, bad_ad} = 7'h40;
    {lv_en, wd_en, stop_ok, bg_ok} = 4'h3;
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    access(1'b0, 1'b0, 8'h00);
    chk("power-on flags", 8'h82, rdata);
    access(1'b0, 1'b1, 8'h00);
    chk("force readback", 8'h00, rdata);
    access(1'b1, 1'b0, 8'hff);
    chk("watchdog restart", 8'h01, {7'h00, restart});
    access(1'b0, 1'b0, 8'h00);
    chk("flags after write", 8'h82, rdata);
    chk("restart after read", 8'h00, {7'h00, restart});
    access(1'b1, 1'b1, 8'h01);
    chk("restart on force write", 8'h00, {7'h00, restart});
    cause(7'h00, 1'b0, 8'h00);
    fork
      u_rcdr_debug_host.force_reset(8'h00, 1'b1);
    join_none
    cause(7'h00, 1'b0, 8'h00);
    lv_en = 1'b1;
    cause(7'h20, 1'b1, 8'h82);
    for (int m = 0; m < 2; m++) begin
      fork
        u_rcdr_debug_host.force_reset(8'h01, 1'(m));
      join_none
      ride_reset(8'h00);
      chk("boot mode", {7'h00, !1'(m)}, {7'h00, boot});
    end
    for (int i = 0; i < 12; i++) begin
      {lv_en, wd_en, stop_ok, bg_ok, v, go, e} = TBL[i];
      cause(v, go, e);
    end
    // The last cause read left a nonzero value, so a stale read would show here.
    access(1'b0, 1'b1, 8'h00);
    chk("force readback after force", 8'h00, rdata);
    conclude();
  end

  // The tests need about 330 cycles; 4000 leaves ample margin.
  initial begin
    #(50 * 4000);
    fails++;
    conclude();
  end
endmodule : rcdr_reset_cause_tb
